/* File: shared/dsw_pkg.sv */
// Package for the drive status word and speed scaling block.
// Assumes one system clock and a register bank reached by holding register number.
package dsw_pkg;

    // Holding register numbers of the output data
    localparam logic [15:0] DSW_REG_STATE_WORD  = 16'hC418; // 50200
    localparam logic [15:0] DSW_REG_OUTPUT_WORD = 16'hC422; // 50210

    // Bit positions in the drive state word
    localparam int DSW_BIT_CTRL_READY  = 0;
    localparam int DSW_BIT_DRIVE_READY = 1;
    localparam int DSW_BIT_ENABLE      = 2;
    localparam int DSW_BIT_TRIP        = 3;
    localparam int DSW_BIT_ERROR       = 4;
    localparam int DSW_BIT_UNUSED      = 5;
    localparam int DSW_BIT_TRIPLOCK    = 6;
    localparam int DSW_BIT_WARNING     = 7;
    localparam int DSW_BIT_AT_REF      = 8;
    localparam int DSW_BIT_BUS_CTRL    = 9;
    localparam int DSW_BIT_FREQ_OK     = 10;
    localparam int DSW_BIT_RUNNING     = 11;
    localparam int DSW_BIT_THERM_STOP  = 12;
    localparam int DSW_BIT_VOLTAGE     = 13;
    localparam int DSW_BIT_TORQUE      = 14;
    localparam int DSW_BIT_TIMER       = 15;

    // Relative scaling: full reference and largest positive word
    localparam logic [15:0] DSW_FULL_SCALE = 16'h4000;
    localparam logic [15:0] DSW_MAX_POS    = 16'h7FFF;

    // Reset values
    localparam logic [15:0] DSW_STATE_RESET  = 16'h0000;
    localparam logic [15:0] DSW_OUTPUT_RESET = 16'h0000;
    localparam logic [15:0] DSW_READ_RESET   = 16'h0000;

    // Internal drive conditions sampled into the state word
    typedef struct packed {
        logic ctrl_ready;
        logic power_ready;
        logic coast_active;
        logic start_cmd;
        logic trip;
        logic trip_reset;
        logic trip_lock;
        logic error_no_trip;
        logic warning;
        logic local_mode;
        logic off_reset_key;
        logic over_temp;
        logic dc_low;
        logic dc_high;
        logic current_over;
        logic motor_timer_over;
        logic inv_timer_over;
    } dsw_cond_type;

    // Frequencies in fixed units, signed
    typedef struct packed {
        logic signed [15:0] out_freq;
        logic signed [15:0] ref_freq;
        logic signed [15:0] low_limit;
        logic signed [15:0] high_limit;
        logic signed [15:0] max_ref;
    } dsw_freq_type;

endpackage : dsw_pkg

/* File: core/dsw_scale.sv */
// Relative speed scaler: maps a signed frequency onto a word where the
// maximum reference equals full scale. Assumes the same clock as the caller.
`timescale 1ns/100ps
`default_nettype none
module dsw_scale (
    input  wire logic               ref_clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic signed [15:0] value_i,
    input  wire logic signed [15:0] max_ref_i,
    output logic        [15:0]      word_o
);
    logic signed [31:0] prod;
    logic signed [31:0] quot;
    logic signed [31:0] sat;
    logic signed [31:0] lim;
    logic        [15:0] word_q;

    // Product then divide; a zero maximum gives zero rather than a fault
    assign prod = 32'(value_i) * 32'(signed'({16'h0000, dsw_pkg::DSW_FULL_SCALE}));
    assign quot = (max_ref_i == 16'sh0000) ? 32'sh0 : prod / 32'(max_ref_i);
    // Saturate so the two's complement word never wraps
    assign lim  = 32'(signed'({16'h0000, dsw_pkg::DSW_MAX_POS}));
    assign sat  = (quot > lim) ? lim :
                  (quot < -lim) ? -lim : quot;

    // Registered so the reported word is a stable flop output
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            word_q <= dsw_pkg::DSW_OUTPUT_RESET;
        end else begin
            word_q <= sat[15:0];
        end
    end

    assign word_o = word_q;
endmodule : dsw_scale
`default_nettype wire

/* File: core/dsw_core.sv */
// Drive status word assembly and actual-value encoding, read as holding registers.
// Assumes condition inputs are on ref_clk_i; external pins are synchronised upstream.
// Summary of operation
// - Bit 0 set when control ready, cleared when tripped.
// - Bit 1 set when ready but coast command still active.
// - Bit 2 low while coasting, high when start command will start motor.
// - Bit 3 shows trip, held until a reset is applied.
// - Bit 4 shows an error that does not trip.
// - Bit 5 unused, always zero.
// - Bit 6 set when tripped and locked.
// - Bit 7 set while any warning exists.
// - Bit 8 set only when speed equals the reference.
// - Bit 9 set when bus control possible, cleared by local or off key.
// - Bit 10 set while frequency lies strictly within limits.
// - Bit 11 set on start signal or positive output frequency.
// - Bit 12 set during temporary over-temperature stop without trip.
// - Bit 13 set when DC link voltage too low or high.
// - Bit 14 set when current limit exceeded.
// - Bit 15 set when either thermal timer exceeds full scale.
// - Reference word is relative; 16384 means full reference.
// - Negative values use two's complement in the same word.
// - Actual output value uses the reference scaling.
// - State word and output value are read at their register numbers.
`timescale 1ns/100ps
`default_nettype none
module dsw_core (
    input  wire logic                  ref_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire dsw_pkg::dsw_cond_type cond_i,
    input  wire dsw_pkg::dsw_freq_type freq_i,
    input  wire logic                  rd_en_i,
    input  wire logic [15:0]           rd_addr_i,
    output logic                       rd_valid_o,
    output logic                       rd_err_o,
    output logic [15:0]                rd_data_o,
    output logic [15:0]                drive_state_word_o,
    output logic [15:0]                output_value_word_o
);
    logic        trip_q;
    logic        trip_d;
    logic        lock_q;
    logic        lock_d;
    logic [15:0] state_q;
    logic [15:0] state_d;
    logic [15:0] rd_data_q;
    logic        rd_valid_q;
    logic        rd_err_q;
    logic        hit_state;
    logic        hit_output;
    logic        in_limits;
    logic        at_ref;
    logic        any_warn;
    logic        volt_bad;

    // trip latch: set wins over the reset strobe
    assign trip_d = cond_i.trip | (trip_q & ~cond_i.trip_reset);
    assign lock_d = (cond_i.trip & cond_i.trip_lock) | (lock_q & trip_d & ~cond_i.trip_reset);

    // Derived conditions
    assign in_limits = (freq_i.out_freq > freq_i.low_limit) &&
                       (freq_i.out_freq < freq_i.high_limit);
    assign at_ref    = (freq_i.out_freq == freq_i.ref_freq);
    assign volt_bad  = cond_i.dc_low | cond_i.dc_high;
    assign any_warn  = cond_i.warning | volt_bad | cond_i.current_over | cond_i.over_temp |
                       cond_i.motor_timer_over | cond_i.inv_timer_over;

    // Next state word, bit by bit
    always_comb begin
        state_d = dsw_pkg::DSW_STATE_RESET;
        state_d[dsw_pkg::DSW_BIT_CTRL_READY]  = cond_i.ctrl_ready & ~trip_d;
        state_d[dsw_pkg::DSW_BIT_DRIVE_READY] = cond_i.ctrl_ready & cond_i.power_ready &
                                                ~trip_d & cond_i.coast_active;
        state_d[dsw_pkg::DSW_BIT_ENABLE]      = ~cond_i.coast_active & ~trip_d;
        state_d[dsw_pkg::DSW_BIT_TRIP]        = trip_d;
        state_d[dsw_pkg::DSW_BIT_ERROR]       = cond_i.error_no_trip & ~trip_d;
        state_d[dsw_pkg::DSW_BIT_UNUSED]      = 1'b0;
        state_d[dsw_pkg::DSW_BIT_TRIPLOCK]    = lock_d;
        state_d[dsw_pkg::DSW_BIT_WARNING]     = any_warn;
        state_d[dsw_pkg::DSW_BIT_AT_REF]      = at_ref;
        state_d[dsw_pkg::DSW_BIT_BUS_CTRL]    = ~cond_i.local_mode & ~cond_i.off_reset_key;
        state_d[dsw_pkg::DSW_BIT_FREQ_OK]     = in_limits;
        state_d[dsw_pkg::DSW_BIT_RUNNING]     = cond_i.start_cmd | (freq_i.out_freq > 16'sh0000);
        state_d[dsw_pkg::DSW_BIT_THERM_STOP]  = cond_i.over_temp & ~trip_d;
        state_d[dsw_pkg::DSW_BIT_VOLTAGE]     = volt_bad;
        state_d[dsw_pkg::DSW_BIT_TORQUE]      = cond_i.current_over;
        state_d[dsw_pkg::DSW_BIT_TIMER]       = cond_i.motor_timer_over | cond_i.inv_timer_over;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            trip_q  <= 1'b0;
            lock_q  <= 1'b0;
            state_q <= dsw_pkg::DSW_STATE_RESET;
        end else begin
            trip_q  <= trip_d;
            lock_q  <= lock_d;
            state_q <= state_d;
        end
    end

    // actual value scaled like the reference
    dsw_scale u_scale (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .value_i   (freq_i.out_freq),
        .max_ref_i (freq_i.max_ref),
        .word_o    (output_value_word_o)
    );

    assign hit_state  = (rd_addr_i == dsw_pkg::DSW_REG_STATE_WORD);
    assign hit_output = (rd_addr_i == dsw_pkg::DSW_REG_OUTPUT_WORD);

    // Read port: one cycle latency, unmapped numbers answer zero with error
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rd_valid_q <= 1'b0;
            rd_err_q   <= 1'b0;
            rd_data_q  <= dsw_pkg::DSW_READ_RESET;
        end else begin
            rd_valid_q <= rd_en_i;
            rd_err_q   <= rd_en_i & ~hit_state & ~hit_output;
            rd_data_q  <= !rd_en_i   ? dsw_pkg::DSW_READ_RESET :
                          hit_state  ? state_q :
                          hit_output ? output_value_word_o : dsw_pkg::DSW_READ_RESET;
        end
    end

    assign rd_valid_o         = rd_valid_q;
    assign rd_err_o           = rd_err_q;
    assign rd_data_o          = rd_data_q;
    assign drive_state_word_o = state_q;

    // Assertions
    property p_trip_hold;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (trip_q && !cond_i.trip_reset) |=> state_q[dsw_pkg::DSW_BIT_TRIP];
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip bit dropped");

    property p_trip_seen;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cond_i.trip |=> state_q[dsw_pkg::DSW_BIT_TRIP] && !state_q[dsw_pkg::DSW_BIT_CTRL_READY];
    endproperty
    a_trip_seen: assert property (p_trip_seen) else $error("trip not shown");

    property p_unused;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !drive_state_word_o[dsw_pkg::DSW_BIT_UNUSED];
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");

    property p_warn;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cond_i.dc_high |=> state_q[dsw_pkg::DSW_BIT_WARNING] && state_q[dsw_pkg::DSW_BIT_VOLTAGE];
    endproperty
    a_warn: assert property (p_warn) else $error("voltage warning missing");

    property p_at_ref;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (freq_i.out_freq != freq_i.ref_freq) |=> !state_q[dsw_pkg::DSW_BIT_AT_REF];
    endproperty
    a_at_ref: assert property (p_at_ref) else $error("at-reference wrong");

    property p_bus;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cond_i.local_mode |=> !state_q[dsw_pkg::DSW_BIT_BUS_CTRL];
    endproperty
    a_bus: assert property (p_bus) else $error("bus control while local");

    property p_run;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (freq_i.out_freq > 16'sh0000) |=> state_q[dsw_pkg::DSW_BIT_RUNNING];
    endproperty
    a_run: assert property (p_run) else $error("running bit missing");

    property p_timer;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_i.motor_timer_over || cond_i.inv_timer_over) |=> state_q[dsw_pkg::DSW_BIT_TIMER];
    endproperty
    a_timer: assert property (p_timer) else $error("timer bit missing");

    property p_full_scale;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (freq_i.out_freq == freq_i.max_ref && freq_i.max_ref > 16'sh0000)
            |=> output_value_word_o == dsw_pkg::DSW_FULL_SCALE;
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("full scale wrong");

    property p_read;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd_en_i && hit_state) |=> rd_valid_o && rd_data_o == $past(state_q);
    endproperty
    a_read: assert property (p_read) else $error("state read wrong");

    property p_ctrl_ready;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_i.ctrl_ready && !cond_i.trip && !trip_q)
            |=> state_q[dsw_pkg::DSW_BIT_CTRL_READY];
    endproperty
    a_ctrl_ready: assert property (p_ctrl_ready) else $error("control ready missing");

    property p_drive_ready;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_i.ctrl_ready && cond_i.power_ready && cond_i.coast_active &&
         !cond_i.trip && !trip_q) |=> state_q[dsw_pkg::DSW_BIT_DRIVE_READY];
    endproperty
    a_drive_ready: assert property (p_drive_ready) else $error("drive ready missing");

    property p_coast;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cond_i.coast_active |=> !state_q[dsw_pkg::DSW_BIT_ENABLE];
    endproperty
    a_coast: assert property (p_coast) else $error("enable while coasting");

    property p_error;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_i.error_no_trip && !cond_i.trip && !trip_q)
            |=> state_q[dsw_pkg::DSW_BIT_ERROR];
    endproperty
    a_error: assert property (p_error) else $error("error bit missing");

    property p_lock;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_i.trip && cond_i.trip_lock)
            |=> state_q[dsw_pkg::DSW_BIT_TRIPLOCK] && state_q[dsw_pkg::DSW_BIT_TRIP];
    endproperty
    a_lock: assert property (p_lock) else $error("triplock missing");

    property p_lock_clear;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (!cond_i.trip && (!trip_q || cond_i.trip_reset))
            |=> !state_q[dsw_pkg::DSW_BIT_TRIPLOCK];
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("triplock without fault");

    property p_warn_in;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cond_i.warning |=> state_q[dsw_pkg::DSW_BIT_WARNING];
    endproperty
    a_warn_in: assert property (p_warn_in) else $error("warning bit missing");

    property p_at_ref_set;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (freq_i.out_freq == freq_i.ref_freq) |=> state_q[dsw_pkg::DSW_BIT_AT_REF];
    endproperty
    a_at_ref_set: assert property (p_at_ref_set) else $error("at-reference missing");

    property p_limits;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (freq_i.out_freq <= freq_i.low_limit || freq_i.out_freq >= freq_i.high_limit)
            |=> !state_q[dsw_pkg::DSW_BIT_FREQ_OK];
    endproperty
    a_limits: assert property (p_limits) else $error("limit bit set at limit");

    property p_not_run;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (!cond_i.start_cmd && freq_i.out_freq <= 16'sh0000)
            |=> !state_q[dsw_pkg::DSW_BIT_RUNNING];
    endproperty
    a_not_run: assert property (p_not_run) else $error("running bit while stopped");

    property p_therm;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_i.over_temp && !cond_i.trip && !trip_q)
            |=> state_q[dsw_pkg::DSW_BIT_THERM_STOP];
    endproperty
    a_therm: assert property (p_therm) else $error("thermal stop missing");

    property p_torque;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cond_i.current_over |=> state_q[dsw_pkg::DSW_BIT_TORQUE];
    endproperty
    a_torque: assert property (p_torque) else $error("torque bit missing");

    property p_neg_sign;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (freq_i.out_freq < 16'sh0000 && freq_i.max_ref > 16'sh0000)
            |=> output_value_word_o[15] || output_value_word_o == 16'h0000;
    endproperty
    a_neg_sign: assert property (p_neg_sign) else $error("negative value not negative");

    property p_neg_full;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (freq_i.out_freq == -freq_i.max_ref && freq_i.max_ref > 16'sh0000)
            |=> output_value_word_o == (16'h0000 - dsw_pkg::DSW_FULL_SCALE);
    endproperty
    a_neg_full: assert property (p_neg_full) else $error("negative full scale wrong");

    property p_read_out;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd_en_i && hit_output) |=> rd_valid_o && rd_data_o == $past(output_value_word_o);
    endproperty
    a_read_out: assert property (p_read_out) else $error("value read wrong");

    property p_read_err;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd_en_i && !hit_state && !hit_output)
            |=> rd_err_o && rd_data_o == dsw_pkg::DSW_READ_RESET;
    endproperty
    a_read_err: assert property (p_read_err) else $error("unmapped read not refused");
endmodule : dsw_core
`default_nettype wire

/* File: dv/dsw_master_model.sv */
// Fieldbus master model: issues single holding-register reads to the block.
// Assumes requests are taken on a rising edge and answered one cycle later.
`timescale 1ns/100ps
`default_nettype none
module dsw_master_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rd_valid_i,
    input  wire logic        rd_err_i,
    input  wire logic [15:0] rd_data_i,
    output logic             rd_en_o,
    output logic [15:0]      rd_addr_o
);
    initial begin
        rd_en_o   = 1'b0;
        rd_addr_o = 16'h0000;
    end

    task automatic do_read(input logic [15:0] addr, output logic [15:0] data,
                           output logic err, output logic vld);
        @(negedge ref_clk_i);
        rd_en_o   = 1'b1;
        rd_addr_o = addr;
        @(negedge ref_clk_i);
        rd_en_o   = 1'b0;
        rd_addr_o = ~addr; // Idle address differs so stale decode shows up
        vld       = rd_valid_i;
        data      = rd_data_i;
        err       = rd_err_i;
    endtask : do_read
endmodule : dsw_master_model
`default_nettype wire

/* File: dv/tb.sv */
// Testbench for the drive status word block: table of cases, then hand tests.
// Assumes the master model drives reads and the bench drives conditions.
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [16:0] c;
        logic [15:0] f;
        logic [15:0] m;
        logic [15:0] ws;
        logic [15:0] wv;
    } dsw_row_type;
    logic                  ref_clk_i, sys_rst_i, rd_en, rd_valid, rd_err, err, vld;
    logic [15:0]           rd_addr, rd_data, state_w, value_w, data;
    dsw_pkg::dsw_cond_type cond;
    dsw_pkg::dsw_freq_type freq;
    int                    num_errors = 0;
    int                    check_count = 0;
    // Conditions, output freq, max reference, state word, value word
    dsw_row_type rows[15] = '{
        '{17'h1A000, 16'h01F4, 16'h03E8, 16'h0F05, 16'h2000},
        '{17'h1C080, 16'h0000, 16'h03E8, 16'h0003, 16'h0000},
        '{17'h00375, 16'h0384, 16'h03E8, 16'hF894, 16'h3999},
        '{17'h1010A, 16'hFF9C, 16'h03E8, 16'hA285, 16'hF99A},
        '{17'h00000, 16'h03E8, 16'h03E8, 16'h0A04, 16'h4000},
        '{17'h00000, 16'hFC18, 16'h03E8, 16'h0204, 16'hC000},
        '{17'h00000, 16'h01F4, 16'h03E8, 16'h0F04, 16'h2000},
        '{17'h00000, 16'h0BB8, 16'h03E8, 16'h0A04, 16'h7FFF},
        '{17'h00000, 16'hF448, 16'h03E8, 16'h0204, 16'h8001},
        '{17'h00000, 16'h0001, 16'h0003, 16'h0A04, 16'h1555},
        '{17'h00000, 16'hFFFF, 16'h0003, 16'h0204, 16'hEAAB},
        '{17'h00000, 16'h00C8, 16'h0000, 16'h0E04, 16'h0000},
        '{17'h00100, 16'h01F4, 16'h03E8, 16'h0F84, 16'h2000},
        '{17'h02000, 16'h0000, 16'h03E8, 16'h0A04, 16'h0000},
        '{17'h14000, 16'h0000, 16'h03E8, 16'h0201, 16'h0000}};

    dsw_core DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cond_i(cond), .freq_i(freq),
        .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid), .rd_err_o(rd_err),
        .rd_data_o(rd_data), .drive_state_word_o(state_w), .output_value_word_o(value_w));
    dsw_master_model M (.ref_clk_i(ref_clk_i), .rd_valid_i(rd_valid), .rd_err_i(rd_err),
        .rd_data_i(rd_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr));

    // 100 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Conditions change at the falling edge, then settle for three cycles
    task automatic apply(input logic [16:0] c, input logic [15:0] f, input logic [15:0] m);
        @(negedge ref_clk_i);
        cond     = dsw_pkg::dsw_cond_type'(c);
        freq     = '{f, 16'sd500, 16'sd100, 16'sd900, m};
        repeat (3) @(negedge ref_clk_i);
    endtask : apply

    task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input logic e);
        M.do_read(addr, data, err, vld);
        chk("read valid", vld, 16'h0001);
        chk("read error", err, e);
        chk("read data", data, exp);
    endtask : rd

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog bounds the whole run
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        sys_rst_i = 1'b1;
        cond      = dsw_pkg::dsw_cond_type'(17'h1A000);
        freq      = '{16'sd500, 16'sd500, 16'sd100, 16'sd900, 16'sd1000};
        repeat (3) @(negedge ref_clk_i);
        chk("state in reset", state_w, dsw_pkg::DSW_STATE_RESET);
        chk("value in reset", value_w, dsw_pkg::DSW_OUTPUT_RESET);
        sys_rst_i = 1'b0;
        foreach (rows[i]) begin
            apply(rows[i].c, rows[i].f, rows[i].m);
            chk("state port", state_w, rows[i].ws);
            chk("value port", value_w, rows[i].wv);
            rd(dsw_pkg::DSW_REG_STATE_WORD, rows[i].ws, 1'b0);
            rd(dsw_pkg::DSW_REG_OUTPUT_WORD, rows[i].wv, 1'b0);
        end
        $display("test table done");
        // Trip latches, masks ready and error bits, and holds until reset
        apply(17'h19720, 16'h0000, 16'h03E8);
        rd(dsw_pkg::DSW_REG_STATE_WORD, 16'h02C8, 1'b0);
        apply(17'h18720, 16'h0000, 16'h03E8);
        rd(dsw_pkg::DSW_REG_STATE_WORD, 16'h02C8, 1'b0);
        apply(17'h18B20, 16'h0000, 16'h03E8);
        rd(dsw_pkg::DSW_REG_STATE_WORD, 16'h1295, 1'b0);
        $display("test trip done");
        // Unmapped number is refused with zero data
        rd(16'hC419, 16'h0000, 1'b1);
        rd(16'hC350, 16'h0000, 1'b1);
        $display("test unmapped done");
        // Reset in mid-run clears both words
        @(negedge ref_clk_i);
        sys_rst_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        chk("state mid reset", state_w, 16'h0000);
        chk("value mid reset", value_w, 16'h0000);
        sys_rst_i = 1'b0;
        // First edge after release must resample the held conditions
        rd(dsw_pkg::DSW_REG_STATE_WORD, 16'h1295, 1'b0);
        $display("test reset done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
